/* common/iuvf_pkg.sv */
/*
 * Constants, types and decode helpers for the input undervoltage
 * fault-response block.
 * Assumes a PMBus front end that hands over decoded command bytes.
 */
package iuvf_pkg;

  // Command codes seen on the decoded command port
  localparam logic [7:0] IUVF_CODE_OPERATION    = 8'h01;
  localparam logic [7:0] IUVF_CODE_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] IUVF_CODE_ACTION       = 8'h5A;
  localparam logic [7:0] IUVF_CODE_STATUS_INPUT = 8'h7C;

  // Field positions
  localparam int IUVF_RESP_LSB   = 6;
  localparam int IUVF_RETRY_LSB  = 3;
  localparam int IUVF_EXP_LSB    = 0;
  localparam int IUVF_OPER_ON    = 7;
  localparam int IUVF_STATUS_UV  = 4;

  // Values after reset
  localparam logic [7:0] IUVF_ACTION_RESET = 8'h80;
  localparam logic [7:0] IUVF_OPER_RESET   = 8'h80;

  localparam logic [2:0] IUVF_RETRY_NONE    = 3'h0;
  localparam logic [2:0] IUVF_RETRY_ENDLESS = 3'h7;

  localparam int IUVF_SYNC_STAGES = 3;
  localparam int IUVF_UNIT_W      = 8;

  typedef enum logic [1:0] {
    IUVF_RESP_IGNORE = 2'h0,
    IUVF_RESP_DELAY  = 2'h1,
    IUVF_RESP_RETRY  = 2'h2,
    IUVF_RESP_LATCH  = 2'h3
  } iuvf_resp_e;

  typedef enum logic [4:0] {
    IUVF_ST_RUN   = 5'h01,
    IUVF_ST_DELAY = 5'h02,
    IUVF_ST_WAIT  = 5'h04,
    IUVF_ST_LATCH = 5'h08,
    IUVF_ST_OFF   = 5'h10
  } iuvf_state_e;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] code;
    logic [7:0] data;
  } iuvf_cmd_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } iuvf_rsp_s;

  // Delay field n selects 2**n units
  function automatic logic [IUVF_UNIT_W-1:0] iuvf_units(
    input logic [2:0] exp_v
  );
    return 8'h01 << exp_v;
  endfunction

endpackage

/* hw/iuvf_delay.sv */
/*
 * Delay timer counting a power-of-two number of delay-unit ticks.
 * Assumes unit_tick_i is a one-cycle pulse on ref_clk_i from the
 * unit-time generator.
 */
module iuvf_delay
  import iuvf_pkg::*;
(
  input  wire logic       ref_clk_i,
  input  wire logic       rst_i,
  input  wire logic       start_i,
  input  wire logic       tick_i,
  input  wire logic [2:0] exp_i,
  output logic            done_o
);

  logic [IUVF_UNIT_W-1:0] cnt_r;
  logic [IUVF_UNIT_W-1:0] cnt_nxt;
  logic                   run_r;
  logic                   run_nxt;
  logic                   last;

  // Unit length itself lives outside; only ticks are counted here
  assign last   = (cnt_r == iuvf_units(exp_i) - 8'h01);  // see [R12]
  // Not gated by start_i: the sequencer restarts on done_o, a loop
  assign done_o = run_r & tick_i & last;                 // see [R14]

  always_comb begin
    cnt_nxt = cnt_r;
    run_nxt = run_r;
    if (start_i) begin
      cnt_nxt = '0;
      run_nxt = 1'b1;
    end else if (run_r && tick_i) begin
      if (last) begin
        run_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= '0;
      run_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      run_r <= run_nxt;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  unit_count_a: assert property ( // see [R12]
    run_r |-> cnt_r < iuvf_units(exp_i))
    else $error("delay count passed its decoded length");

  done_pulse_a: assert property ( // see [R10]
    done_o && !start_i |=> !done_o)
    else $error("delay done held longer than one cycle");

endmodule

/* hw/iuvf_core.sv */
/*
 * Input undervoltage fault response: action register, fault flag,
 * delay / retry / latch sequencing and output enable.
 * Assumes a PMBus front end delivering decoded commands, an analog
 * comparator flag and remote on/off pin, and a delay-unit tick.
 */
// Overview of operation
// [R1] Flag undervoltage and apply the configured response
// [R2] Response zero keeps the output regulating
// [R3] Response one runs for delay, then retries
// [R4] Response two disables at once, then retries
// [R5] Response three latches off until cleared
// [R6] Status clear, clear-faults or reset unlatch
// [R7] Output off then on also clears
// [R8] Retry zero means no restart, stay off
// [R9] Retries one to six, then latch off
// [R10] Attempts spaced by decoded delay units
// [R11] Retry seven repeats until off or fault
// [R12] Delay field n gives two to n units
// [R13] Delay serves as run time or spacing
// [R14] Unit length comes from a separate register
// [R15] Clearing restarts the retry sequence afresh
module iuvf_core
  import iuvf_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire logic      rst_i,
  input  wire iuvf_cmd_s cmd_i,
  input  wire logic      uv_fault_pin_i,
  input  wire logic      ctrl_on_pin_i,
  input  wire logic      unit_tick_i,
  input  wire logic      other_fault_i,
  output iuvf_rsp_s      rsp_o,
  output logic           out_enable_o,
  output logic           fault_latched_o,
  output logic           uv_status_o
);

  localparam int NPIN = 2;

  logic [IUVF_SYNC_STAGES-1:0] sync_r [NPIN];
  logic [NPIN-1:0]             pin_r;
  logic [NPIN-1:0]             pin_nxt;
  logic                        fault_s;
  logic                        on_pin;

  logic [7:0]  action_r;
  logic [7:0]  action_nxt;
  logic [7:0]  oper_r;
  logic [7:0]  oper_nxt;
  logic        status_r;
  logic        status_nxt;
  iuvf_rsp_s   rsp_r;
  iuvf_rsp_s   rsp_nxt;

  iuvf_state_e state_r;
  iuvf_state_e state_nxt;
  logic [2:0]  att_r;
  logic [2:0]  att_nxt;
  logic [2:0]  att_inc;
  logic        tmr_start;
  logic        tmr_done;

  logic        wr;
  logic        clear_faults;
  logic        status_clr;
  logic        clear_evt;
  logic        on;
  iuvf_resp_e  resp;
  logic [2:0]  retries;
  logic [2:0]  dly_exp;

  // Three stages; a level change is taken only once stages 2 and 3
  // agree, so a glitch caught by the first stage never propagates.
  for (genvar g = 0; g < NPIN; g++) begin : g_sync
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
        sync_r[g] <= '0;
      end else begin
        sync_r[g] <= {sync_r[g][IUVF_SYNC_STAGES-2:0],
                      (g == 0) ? uv_fault_pin_i : ctrl_on_pin_i};
      end
    end
    always_comb begin
      pin_nxt[g] = pin_r[g];
      if (sync_r[g][1] == sync_r[g][2]) begin
        pin_nxt[g] = sync_r[g][2];
      end
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_r <= '0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  assign fault_s = pin_r[0];                             // see [R1]
  assign on_pin  = pin_r[1];

  assign resp    = iuvf_resp_e'(action_r[IUVF_RESP_LSB +: 2]);
  assign retries = action_r[IUVF_RETRY_LSB +: 3];
  assign dly_exp = action_r[IUVF_EXP_LSB +: 3];

  assign wr           = cmd_i.valid & cmd_i.write;
  assign clear_faults = wr & (cmd_i.code == IUVF_CODE_CLEAR_FAULTS);
  assign status_clr   = wr & (cmd_i.code == IUVF_CODE_STATUS_INPUT)
                        & cmd_i.data[IUVF_STATUS_UV];
  assign clear_evt    = clear_faults | status_clr;       // see [R6]
  // Pin and command combine: either may turn the output off
  assign on           = on_pin & oper_r[IUVF_OPER_ON];   // see [R7]

  always_comb begin
    action_nxt = action_r;
    oper_nxt   = oper_r;
    status_nxt = status_r;
    rsp_nxt    = '0;
    if (wr && cmd_i.code == IUVF_CODE_ACTION) begin
      action_nxt = cmd_i.data;
    end
    if (wr && cmd_i.code == IUVF_CODE_OPERATION) begin
      oper_nxt = cmd_i.data;
    end
    // A fault present in the clearing cycle keeps the bit set
    if (fault_s) begin
      status_nxt = 1'b1;                                 // see [R1]
    end else if (clear_evt) begin
      status_nxt = 1'b0;                                 // see [R6]
    end
    if (cmd_i.valid && !cmd_i.write) begin
      rsp_nxt.valid = 1'b1;
      case (cmd_i.code)
        IUVF_CODE_ACTION:       rsp_nxt.data = action_r;
        IUVF_CODE_OPERATION:    rsp_nxt.data = oper_r;
        IUVF_CODE_STATUS_INPUT: rsp_nxt.data[IUVF_STATUS_UV] = status_r;
        default:                rsp_nxt.data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      action_r <= IUVF_ACTION_RESET;
      oper_r   <= IUVF_OPER_RESET;
      status_r <= 1'b0;
      rsp_r    <= '0;
    end else begin
      action_r <= action_nxt;
      oper_r   <= oper_nxt;
      status_r <= status_nxt;
      rsp_r    <= rsp_nxt;
    end
  end

  // Shared timer: run time under response one, spacing under retry
  iuvf_delay u_delay (                                   // see [R13]
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .start_i   (tmr_start),
    .tick_i    (unit_tick_i),
    .exp_i     (dly_exp),
    .done_o    (tmr_done)
  );

  assign att_inc = att_r + 3'h1;

  always_comb begin
    state_nxt = state_r;
    att_nxt   = att_r;
    tmr_start = 1'b0;
    if (!on) begin
      state_nxt = IUVF_ST_OFF;                           // see [R11]
    end else begin
      case (state_r)
        IUVF_ST_OFF: begin
          state_nxt = IUVF_ST_RUN;                       // see [R7]
        end
        IUVF_ST_RUN: begin
          if (other_fault_i) begin
            state_nxt = IUVF_ST_LATCH;
          end else if (fault_s) begin
            case (resp)
              IUVF_RESP_IGNORE: state_nxt = IUVF_ST_RUN; // see [R2]
              IUVF_RESP_DELAY: begin
                state_nxt = IUVF_ST_DELAY;               // see [R3]
                tmr_start = 1'b1;
              end
              IUVF_RESP_RETRY: begin                     // see [R4]
                if (retries == IUVF_RETRY_NONE) begin
                  state_nxt = IUVF_ST_LATCH;             // see [R8]
                end else begin
                  state_nxt = IUVF_ST_WAIT;
                  tmr_start = 1'b1;
                end
              end
              default: state_nxt = IUVF_ST_LATCH;        // see [R5]
            endcase
          end
        end
        IUVF_ST_DELAY: begin
          if (other_fault_i) begin
            state_nxt = IUVF_ST_LATCH;
          end else if (!fault_s) begin
            state_nxt = IUVF_ST_RUN;
          end else if (tmr_done) begin                   // see [R3]
            if (retries == IUVF_RETRY_NONE) begin
              state_nxt = IUVF_ST_LATCH;                 // see [R8]
            end else begin
              state_nxt = IUVF_ST_WAIT;
              tmr_start = 1'b1;
            end
          end
        end
        IUVF_ST_WAIT: begin
          if (other_fault_i) begin
            state_nxt = IUVF_ST_LATCH;                   // see [R11]
          end else if (tmr_done) begin                   // see [R10]
            if (!fault_s) begin
              state_nxt = IUVF_ST_RUN;
            end else if (retries != IUVF_RETRY_ENDLESS
                         && att_inc >= retries) begin
              state_nxt = IUVF_ST_LATCH;                 // see [R9]
            end else begin
              // Endless mode never counts, so it cannot wrap
              if (retries != IUVF_RETRY_ENDLESS) begin
                att_nxt = att_inc;
              end
              tmr_start = 1'b1;
            end
          end
        end
        IUVF_ST_LATCH: begin
          if (clear_evt) begin
            state_nxt = IUVF_ST_RUN;                     // see [R6]
          end
        end
        default: state_nxt = IUVF_ST_LATCH;
      endcase
    end
    if (state_nxt != IUVF_ST_WAIT) begin
      att_nxt = 3'h0;                                    // see [R15]
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= IUVF_ST_RUN;
      att_r   <= 3'h0;
    end else begin
      state_r <= state_nxt;
      att_r   <= att_nxt;
    end
  end

  assign out_enable_o    = (state_r == IUVF_ST_RUN)
                           | (state_r == IUVF_ST_DELAY);
  assign fault_latched_o = (state_r == IUVF_ST_LATCH);
  assign uv_status_o     = status_r;
  assign rsp_o           = rsp_r;

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  ignore_keeps_on_a: assert property ( // see [R2]
    state_r == IUVF_ST_RUN && fault_s && resp == IUVF_RESP_IGNORE
    && on && !other_fault_i |=> out_enable_o)
    else $error("ignore response dropped the output");

  delay_runs_on_a: assert property ( // see [R3]
    state_r == IUVF_ST_DELAY && fault_s && !tmr_done && on
    && !other_fault_i |=> out_enable_o)
    else $error("output off during operating delay");

  disable_now_a: assert property ( // see [R4]
    state_r == IUVF_ST_RUN && fault_s && resp == IUVF_RESP_RETRY
    && on |=> !out_enable_o)
    else $error("retry response did not disable at once");

  latch_holds_a: assert property ( // see [R5]
    fault_latched_o && on && !clear_evt |=> fault_latched_o)
    else $error("latched fault released without a clear");

  clear_unlatch_a: assert property ( // see [R6]
    fault_latched_o && on && clear_faults |=> out_enable_o)
    else $error("clear did not release latched fault");

  on_cycle_a: assert property ( // see [R7]
    state_r == IUVF_ST_OFF && on |=> state_r == IUVF_ST_RUN)
    else $error("off then on did not restart output");

  no_retry_a: assert property ( // see [R8]
    state_r == IUVF_ST_RUN && fault_s && on && !other_fault_i
    && resp == IUVF_RESP_RETRY && retries == IUVF_RETRY_NONE
    |=> fault_latched_o)
    else $error("zero retries did not latch off");

  retry_limit_a: assert property ( // see [R9]
    state_r == IUVF_ST_WAIT && retries != IUVF_RETRY_ENDLESS
    |-> att_r < retries)
    else $error("attempt count exceeded retry setting");

  endless_retry_a: assert property ( // see [R11]
    state_r == IUVF_ST_WAIT && retries == IUVF_RETRY_ENDLESS && on
    && !other_fault_i |=> !fault_latched_o)
    else $error("endless retry latched off");

  fresh_count_a: assert property ( // see [R15]
    state_r != IUVF_ST_WAIT |-> att_r == 3'h0)
    else $error("attempt counter not cleared");

  cov_latch_c: cover property (fault_latched_o ##1 !fault_latched_o);
  cov_retry_ok_c: cover property (
    state_r == IUVF_ST_WAIT ##1 state_r == IUVF_ST_RUN);
  cov_delay_c: cover property (
    state_r == IUVF_ST_DELAY ##1 state_r == IUVF_ST_WAIT);
  cov_on_c: cover property (state_r == IUVF_ST_OFF ##1 out_enable_o);

endmodule

/* tb/iuvf_host.sv */
/*
 * Host-side model: issues decoded PMBus commands to the fault-response
 * block, one byte per command, and collects read answers.
 * Assumes the block samples cmd_o on the rising edge of ref_clk_i.
 */
module iuvf_host
  import iuvf_pkg::*;
(
  input  wire logic      ref_clk_i,
  input  wire iuvf_rsp_s rsp_i,
  output iuvf_cmd_s      cmd_o
);
  timeunit 1ns;
  timeprecision 1ns;

  initial cmd_o = '0;

  // Write or send byte; also clear and on/off
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    @(posedge ref_clk_i);
    cmd_o <= '{valid: 1'b1, write: 1'b1, code: code, data: data};
    @(posedge ref_clk_i);
    cmd_o <= '0;
  endtask

  // Bounded wait so a missing answer shows as unknown data
  task automatic fetch(input logic [7:0] code, output logic [7:0] data);
    int n;
    data = 'x;
    n = 0;
    @(posedge ref_clk_i);
    cmd_o <= '{valid: 1'b1, write: 1'b0, code: code, data: 8'h00};
    @(posedge ref_clk_i);
    cmd_o <= '0;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (rsp_i.valid !== 1'b1 && n < 4);
    if (rsp_i.valid === 1'b1) begin
      data = rsp_i.data;
    end
  endtask
endmodule

/* tb/input_undervolt_fault_response_tb.sv */
/*
 * Self-checking bench for the input undervoltage fault response.
 * Assumes the host model drives commands and the bench drives the pins
 * and delay-unit ticks, all on the rising edge of ref_clk_i.
 */
module input_undervolt_fault_response_tb
  import iuvf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic       ref_clk_i;
  logic       rst_i;
  logic       uv_pin;
  logic       on_pin;
  logic       tick_r;
  logic       other;
  iuvf_cmd_s  cmd;
  iuvf_rsp_s  rsp;
  logic       en;
  logic       latched;
  logic       status;
  logic [7:0] rd;
  int         fails;
  int         total_checks;
  int         cycles;

  // Action bytes covering responses one to three and every retry code
  localparam logic [7:0] CASES [10] = '{8'h79, 8'h42, 8'h50, 8'h80, 8'h8F,
                                        8'h9A, 8'hA9, 8'hB0, 8'hB8, 8'hE1};

  iuvf_core uut (
    .ref_clk_i       (ref_clk_i),
    .rst_i           (rst_i),
    .cmd_i           (cmd),
    .uv_fault_pin_i  (uv_pin),
    .ctrl_on_pin_i   (on_pin),
    .unit_tick_i     (tick_r),
    .other_fault_i   (other),
    .rsp_o           (rsp),
    .out_enable_o    (en),
    .fault_latched_o (latched),
    .uv_status_o     (status)
  );

  iuvf_host host (
    .ref_clk_i (ref_clk_i),
    .rsp_i     (rsp),
    .cmd_o     (cmd)
  );

  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  task automatic test_done();
    if (fails == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Generous ceiling: the longest case needs about 300 cycles
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask

  // Pulses n unit ticks, then lets the state settle
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge ref_clk_i);
      tick_r <= 1'b1;
      @(posedge ref_clk_i);
      tick_r <= 1'b0;
    end
    cyc(3);
  endtask

  task automatic run(input logic [7:0] a);
    logic [1:0] rs;
    logic [2:0] rt;
    int         u;
    rs = a[7:6];
    rt = a[5:3];
    u = 1 << a[2:0];
    host.send(IUVF_CODE_ACTION, a);
    host.fetch(IUVF_CODE_ACTION, rd);
    check(rd, a);
    uv_pin <= 1'b1;
    cyc(8);
    check(en, {7'h00, rs == 2'h1});
    if (rs == 2'h1) begin
      tick(u - 1);
      check(en, 8'h01);
      tick(1);
      check(en, 8'h00);
    end
    if (rs == 2'h3 || rt == IUVF_RETRY_NONE) begin
      check(latched, 8'h01);
    end else if (rt != IUVF_RETRY_ENDLESS) begin
      tick(rt * u - 1);
      check(latched, 8'h00);
      tick(1);
      check(latched, 8'h01);
    end else begin
      tick(10 * u);
      check(latched, 8'h00);
    end
    uv_pin <= 1'b0;
    cyc(8);
    if (rt == IUVF_RETRY_ENDLESS) begin
      tick(u - 1);
      check(en, 8'h00);
      tick(1);
      check(en, 8'h01);
    end
    host.send(IUVF_CODE_CLEAR_FAULTS, 8'h00);
    cyc(3);
    check(latched, 8'h00);
    check(en, 8'h01);
  endtask

  initial begin
    rst_i = 1'b1;
    uv_pin = 1'b0;
    on_pin = 1'b1;
    tick_r = 1'b0;
    other = 1'b0;
    fails = 0;
    total_checks = 0;
    cycles = 0;
    repeat (4) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    cyc(8);
    check(en, 8'h01);
    host.fetch(IUVF_CODE_ACTION, rd);
    check(rd, IUVF_ACTION_RESET);
    host.fetch(IUVF_CODE_OPERATION, rd);
    check(rd, IUVF_OPER_RESET);
    host.fetch(8'h20, rd);
    check(rd, 8'h00);
    // Ignore: output stays up, status still records the fault
    host.send(IUVF_CODE_ACTION, 8'h07);
    uv_pin <= 1'b1;
    cyc(8);
    tick(128);
    check(en, 8'h01);
    host.fetch(IUVF_CODE_STATUS_INPUT, rd);
    check(rd, 8'h10);
    uv_pin <= 1'b0;
    cyc(8);
    host.send(IUVF_CODE_STATUS_INPUT, 8'h10);
    cyc(3);
    check(status, 8'h00);
    foreach (CASES[i]) begin
      run(CASES[i]);
    end
    // Latch, then clear by pin off and on
    host.send(IUVF_CODE_ACTION, 8'hC0);
    uv_pin <= 1'b1;
    cyc(8);
    check(latched, 8'h01);
    uv_pin <= 1'b0;
    cyc(8);
    on_pin <= 1'b0;
    cyc(8);
    check(en, 8'h00);
    on_pin <= 1'b1;
    cyc(8);
    check(latched, 8'h00);
    check(en, 8'h01);
    // Latch, then clear by the individual status bit
    uv_pin <= 1'b1;
    cyc(8);
    check(latched, 8'h01);
    uv_pin <= 1'b0;
    cyc(8);
    host.send(IUVF_CODE_STATUS_INPUT, 8'h10);
    cyc(3);
    check(latched, 8'h00);
    check(en, 8'h01);
    // Latch, then clear by commanding off and on
    uv_pin <= 1'b1;
    cyc(8);
    check(latched, 8'h01);
    uv_pin <= 1'b0;
    cyc(8);
    host.send(IUVF_CODE_OPERATION, 8'h00);
    cyc(3);
    check(en, 8'h00);
    host.send(IUVF_CODE_OPERATION, 8'h80);
    cyc(3);
    check(latched, 8'h00);
    check(en, 8'h01);
    // Another fault forces shutdown; reset clears it
    other <= 1'b1;
    cyc(2);
    other <= 1'b0;
    cyc(2);
    check(latched, 8'h01);
    rst_i <= 1'b1;
    cyc(2);
    rst_i <= 1'b0;
    cyc(8);
    check(latched, 8'h00);
    check(en, 8'h01);
    test_done();
  end
endmodule
